// *** inc/tlp_pkg.sv ***
// package: constants, register map and types of the tri-level dual-phase pwm sequencer
`default_nettype none

package tlp_pkg;
	// timing, system clock 200 MHz
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned CLK_MHZ     = CLK_HZ / 1_000_000;
	localparam int unsigned OSC_MIN_HZ  = 500_000;
	localparam int unsigned OSC_MAX_HZ  = 3_000_000;
	localparam int unsigned OSC_PER_MIN = (CLK_HZ + OSC_MAX_HZ - 1) / OSC_MAX_HZ;
	localparam int unsigned OSC_PER_MAX = CLK_HZ / OSC_MIN_HZ;
	localparam int unsigned OSC_PER_W   = 16;
	localparam logic [15:0] OSC_PER_RST = 16'h00C8;
	localparam int unsigned MIN_ON_NS   = 100;
	localparam int unsigned MIN_ON_CYC  = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TRI_TIME_NS = 60_000;
	localparam int unsigned TRI_CYC     = TRI_TIME_NS * CLK_MHZ / 1000;
	localparam int unsigned BOOT_FIRST  = 32;
	localparam int unsigned BOOT_EXTRA  = 4;
	localparam int unsigned NUM_PHASES  = 2;

	// tri-level pwm codes
	typedef logic [1:0] tlp_lvl_t;
	localparam tlp_lvl_t LVL_MID  = 2'h0;
	localparam tlp_lvl_t LVL_HIGH = 2'h1;
	localparam tlp_lvl_t LVL_LOW  = 2'h2;

	// sync out strap codes
	localparam logic [1:0] SO_OPEN = 2'h0;
	localparam logic [1:0] SO_OSC  = 2'h1;
	localparam logic [1:0] SO_SW   = 2'h2;

	// apb register byte offsets
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_OSC   = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_MASK  = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;

	// control bits, status bits
	localparam int unsigned CTRL_EN_BIT  = 0;
	localparam int unsigned CTRL_TRI_BIT = 1;
	localparam int unsigned ST_BOOT_DONE = 0;
	localparam int unsigned ST_REFRESH   = 1;
	localparam int unsigned ST_SYNC_LOST = 2;
	localparam int unsigned ST_FAULT     = 3;
	localparam int unsigned STAT_W       = 4;

	// sequencer states
	typedef enum logic [4:0] {
		TLP_IDLE  = 5'b00001,
		TLP_BOOT  = 5'b00010,
		TLP_RUN   = 5'b00100,
		TLP_TRI   = 5'b01000,
		TLP_FAULT = 5'b10000
	} tlp_state_e;
endpackage

`default_nettype wire

// *** rtl/tlp_osc.sv ***
// oscillator tick generator with external sync lock and internal fallback
`default_nettype none

module tlp_osc #(
	parameter int unsigned PER_W = tlp_pkg::OSC_PER_W
) (
	// clock, reset, enable
	input  wire logic             i_sys_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_clk_en,
	// period and external clock
	input  wire logic [PER_W-1:0] i_period,
	input  wire logic             i_sync_in,
	// tick and status
	output logic                  o_tick,
	output logic                  o_osc_lvl,
	output logic                  o_locked,
	output logic                  o_sync_lost
);
	import tlp_pkg::*;

	logic [PER_W-1:0] cnt_r;
	logic             sync_d_r;
	logic             lvl_r;
	logic             locked_r;
	logic             lost_r;
	logic             sync_edge;
	logic             expire;

	// internal period is set longer than sync, so a live sync edge always wins
	assign sync_edge   = i_sync_in & ~sync_d_r;
	assign expire      = (cnt_r >= (i_period - 1'b1));
	assign o_tick      = sync_edge | expire;
	assign o_osc_lvl   = lvl_r;
	assign o_locked    = locked_r;
	assign o_sync_lost = lost_r;

	// period counter restarts on every tick
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			cnt_r <= '0;
		end else if (i_clk_en) begin
			cnt_r <= o_tick ? '0 : cnt_r + 1'b1;
		end
	end

	// sync edge detect, lock flag and loss pulse
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sync_d_r <= 1'b0;
			locked_r <= 1'b0;
			lost_r   <= 1'b0;
		end else if (i_clk_en) begin
			sync_d_r <= i_sync_in;
			lost_r   <= expire & locked_r;
			if (sync_edge) begin
				locked_r <= 1'b1;
			end else if (expire) begin
				locked_r <= 1'b0;
			end
		end
	end

	// square wave at oscillator rate for the sync output
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			lvl_r <= 1'b0;
		end else if (i_clk_en) begin
			if (o_tick) begin
				lvl_r <= 1'b1;
			end else if (cnt_r == (i_period >> 1)) begin
				lvl_r <= 1'b0;
			end
		end
	end

	AST_OSC_NO_GAP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(cnt_r < i_period) || (i_period == '0) || !$stable(i_period)) // shortened period overruns once
		else $error("oscillator gap longer than period");
endmodule

`default_nettype wire

// *** rtl/tlp_seq.sv ***
// tri-level dual-phase pwm sequencer top with apb registers
`default_nettype none

module tlp_seq #(
	parameter int unsigned MIN_ON     = tlp_pkg::MIN_ON_CYC,
	parameter int unsigned TRI_CYCLES = tlp_pkg::TRI_CYC
) (
	// clock, reset, enable
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_clk_en,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// straps and analog status
	input  wire logic [1:0]  i_phase_tied_vcc,
	input  wire logic [1:0]  i_sync_out_strap,
	input  wire logic        i_freq_set_short,
	input  wire logic        i_sync_in,
	input  wire logic [1:0]  i_cur_cmp,
	// pwm and clock outputs
	output tlp_pkg::tlp_lvl_t o_phase_one_pwm_out,
	output tlp_pkg::tlp_lvl_t o_phase_two_pwm_out,
	output logic             o_sync_out,
	output logic             o_irq
);
	import tlp_pkg::*;

	localparam int unsigned    ONC_W     = $clog2(MIN_ON + 1);
	localparam int unsigned    TMR_W     = $clog2(TRI_CYCLES + 1);
	localparam logic [ONC_W-1:0] ONC_LOAD = ONC_W'(MIN_ON - 1);
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(TRI_CYCLES - 1);
	localparam logic [5:0]     TGT_FIRST = 6'(BOOT_FIRST);
	localparam logic [5:0]     TGT_EXTRA = 6'(BOOT_EXTRA);
	localparam logic [15:0]    PER_LO    = 16'(OSC_PER_MIN);
	localparam logic [15:0]    PER_HI    = 16'(OSC_PER_MAX);
	localparam logic [ONC_W:0] MIN_ON_LEN = (ONC_W+1)'(MIN_ON);

	function automatic logic is_high(input tlp_lvl_t l);
		return l == LVL_HIGH;
	endfunction

	function automatic logic is_low(input tlp_lvl_t l);
		return l == LVL_LOW;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == REG_CTRL) || (a == REG_OSC) || (a == REG_STAT) || (a == REG_MASK) || (a == REG_STATE);
	endfunction

	// clamps software period into the supported oscillator range
	function automatic logic [15:0] clamp_per(input logic [15:0] p);
		return (p < PER_LO) ? PER_LO : ((p > PER_HI) ? PER_HI : p);
	endfunction

	tlp_state_e            state_r;
	logic [5:0]            tgt_r;
	logic [5:0]            bcnt_r;
	logic                  toggle_r;
	logic [1:0]            tied_r;
	logic [1:0]            so_mode_r;
	logic                  strap_done_r;
	logic                  armed_r;
	logic [TMR_W-1:0]      tmr_r;
	logic                  pend_r;
	logic                  ctrl_en_r;
	logic                  ctrl_tri_r;
	logic [15:0]           osc_per_r;
	logic [STAT_W-1:0]     stat_r;
	logic [STAT_W-1:0]     mask_r;
	logic [31:0]           prdata_r;
	logic                  pslverr_r;
	logic                  sync_out_r;
	logic [31:0]           rd_word;
	logic [STAT_W-1:0]     stat_set;
	logic [STAT_W-1:0]     stat_clr;
	tlp_lvl_t [NUM_PHASES-1:0] lvl;
	logic [NUM_PHASES-1:0] hi_set;
	logic [NUM_PHASES-1:0] active;
	logic                  osc_tick;
	logic                  osc_lvl;
	logic                  locked;
	logic                  sync_lost;
	logic                  slot1;
	logic                  run;
	logic                  boot;
	logic                  boot_end;
	logic                  tmr_exp;
	logic                  fault_act;
	logic                  apb_setup;
	logic                  apb_access;
	logic                  apb_wr;

	tlp_osc #(
		.PER_W (OSC_PER_W)
	) u_osc (
		.i_sys_clk   (i_sys_clk),
		.i_nrst      (i_nrst),
		.i_clk_en    (i_clk_en),
		.i_period    (clamp_per(osc_per_r)),
		.i_sync_in   (i_sync_in),
		.o_tick      (osc_tick),
		.o_osc_lvl   (osc_lvl),
		.o_locked    (locked),
		.o_sync_lost (sync_lost)
	);

	// decoded sequencer conditions
	assign slot1     = osc_tick & toggle_r;
	assign run       = (state_r == TLP_RUN);
	assign boot      = (state_r == TLP_BOOT);
	assign active    = ~tied_r & {NUM_PHASES{strap_done_r}};
	assign fault_act = i_freq_set_short;
	assign boot_end  = boot & osc_tick & ~toggle_r & (bcnt_r == tgt_r);
	assign tmr_exp   = (state_r == TLP_TRI) & armed_r & (tmr_r == TMR_LAST);

	// straps are sampled once, on the first enabled edge after reset
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			strap_done_r <= 1'b0;
			tied_r       <= 2'h0;
			so_mode_r    <= SO_OPEN;
		end else if (i_clk_en && !strap_done_r) begin
			strap_done_r <= 1'b1;
			tied_r       <= i_phase_tied_vcc;
			so_mode_r    <= i_sync_out_strap;
		end
	end

	// switching clock is the oscillator divided by two
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			toggle_r <= 1'b0;
		end else if (i_clk_en && osc_tick) begin
			toggle_r <= ~toggle_r;
		end
	end

	// main sequencer; fault overrides everything, then enable
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state_r <= TLP_IDLE;
			tgt_r   <= TGT_FIRST;
		end else if (i_clk_en) begin
			if (fault_act) begin
				state_r <= TLP_FAULT;
			end else if (!ctrl_en_r && state_r != TLP_FAULT) begin
				state_r <= TLP_IDLE;
			end else begin
				case (state_r)
					TLP_IDLE: begin
						// starting on a phase-two tick keeps both phases at equal counts
						if (strap_done_r && slot1) begin
							state_r <= TLP_BOOT;
							tgt_r   <= TGT_FIRST;
						end
					end
					TLP_BOOT: begin
						if (boot_end) begin
							state_r <= ctrl_tri_r ? TLP_TRI : TLP_RUN;
						end
					end
					TLP_RUN: begin
						if (ctrl_tri_r) begin
							state_r <= TLP_TRI;
						end
					end
					TLP_TRI: begin
						if (!ctrl_tri_r) begin
							state_r <= TLP_RUN;
						end else if (pend_r && slot1) begin
							state_r <= TLP_BOOT;
							tgt_r   <= TGT_EXTRA;
						end
					end
					TLP_FAULT: begin
						state_r <= TLP_IDLE;
					end
					default: begin
						state_r <= TLP_IDLE;
					end
				endcase
			end
		end
	end

	// refresh pulse counter, one step per switching period
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			bcnt_r <= 6'h00;
		end else if (i_clk_en) begin
			if (!boot) begin
				bcnt_r <= 6'h00;
			end else if (slot1 && bcnt_r < tgt_r) begin
				bcnt_r <= bcnt_r + 6'h01;
			end
		end
	end

	// tristate timer; armed by a high command or the first boot, one shot per arm
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			armed_r <= 1'b0;
			tmr_r   <= '0;
			pend_r  <= 1'b0;
		end else if (i_clk_en) begin
			if (|hi_set) begin
				armed_r <= 1'b1;
			end else if (boot_end && tgt_r == TGT_FIRST) begin
				armed_r <= 1'b1;
			end else if (tmr_exp) begin
				armed_r <= 1'b0;
			end
			if (state_r != TLP_TRI || (|hi_set)) begin
				tmr_r <= '0;
			end else if (armed_r && !tmr_exp) begin
				tmr_r <= tmr_r + 1'b1;
			end
			if (tmr_exp) begin
				pend_r <= 1'b1;
			end else if (state_r != TLP_TRI) begin
				pend_r <= 1'b0;
			end
		end
	end

	// per-phase tri-level drivers
	for (genvar p = 0; p < NUM_PHASES; p++) begin : g_ph
		tlp_lvl_t         lvl_r;
		logic [ONC_W-1:0] onc_r;
		logic             start;
		// phase two starts on the odd tick, half a switching period later
		assign start     = osc_tick & (toggle_r == 1'(p));
		assign hi_set[p] = run & active[p] & start;
		assign lvl[p]    = lvl_r;
		always_ff @(posedge i_sys_clk) begin
			if (!i_nrst) begin
				lvl_r <= LVL_MID;
				onc_r <= '0;
			end else if (i_clk_en) begin
				if (hi_set[p]) begin
					lvl_r <= LVL_HIGH;
				end else if (run && is_high(lvl_r) && i_cur_cmp[p]) begin
					lvl_r <= LVL_LOW;
				end else if (boot && active[p] && start && bcnt_r < tgt_r) begin
					lvl_r <= LVL_LOW;
					onc_r <= ONC_LOAD;
				end else if (boot && is_low(lvl_r)) begin
					if (onc_r == '0) begin
						lvl_r <= LVL_MID;
					end else begin
						onc_r <= onc_r - 1'b1;
					end
				end else if (!run) begin
					lvl_r <= LVL_MID;
				end
			end
		end
	end

	assign o_phase_one_pwm_out = lvl[0];
	assign o_phase_two_pwm_out = lvl[1];

	// sync output source follows the strap, forced low in fault
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sync_out_r <= 1'b0;
		end else if (i_clk_en) begin
			if (state_r == TLP_FAULT) begin
				sync_out_r <= 1'b0;
			end else begin
				case (so_mode_r)
					SO_OSC:  sync_out_r <= osc_lvl;
					SO_SW:   sync_out_r <= toggle_r;
					default: sync_out_r <= is_high(lvl[1]);
				endcase
			end
		end
	end

	assign o_sync_out = sync_out_r;

	// apb: zero wait states, read data captured in the setup cycle
	assign apb_setup  = i_psel & ~i_penable;
	assign apb_access = i_psel & i_penable;
	assign apb_wr     = apb_access & i_pwrite & ~pslverr_r;
	assign o_pready   = apb_access;
	assign o_pslverr  = apb_access & pslverr_r;
	assign o_prdata   = prdata_r;

	// read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		case (i_paddr)
			REG_CTRL:  rd_word = {30'h0, ctrl_tri_r, ctrl_en_r};
			REG_OSC:   rd_word = {16'h0000, osc_per_r};
			REG_STAT:  rd_word = {{(32-STAT_W){1'b0}}, stat_r};
			REG_MASK:  rd_word = {{(32-STAT_W){1'b0}}, mask_r};
			REG_STATE: rd_word = {22'h0, so_mode_r, tied_r, locked, state_r};
			default:   rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (i_clk_en && apb_setup) begin
			prdata_r  <= i_pwrite ? 32'h0000_0000 : rd_word;
			pslverr_r <= ~is_mapped(i_paddr);
		end
	end

	// writable registers
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			ctrl_en_r  <= 1'b0;
			ctrl_tri_r <= 1'b0;
			osc_per_r  <= OSC_PER_RST;
			mask_r     <= '0;
		end else if (i_clk_en && apb_wr) begin
			if (i_paddr == REG_CTRL) begin
				ctrl_en_r  <= i_pwdata[CTRL_EN_BIT];
				ctrl_tri_r <= i_pwdata[CTRL_TRI_BIT];
			end
			if (i_paddr == REG_OSC) begin
				osc_per_r <= i_pwdata[15:0];
			end
			if (i_paddr == REG_MASK) begin
				mask_r <= i_pwdata[STAT_W-1:0];
			end
		end
	end

	// sticky status; only bits already seen by the read are cleared, and set wins
	always_comb begin
		stat_set               = '0;
		stat_set[ST_BOOT_DONE] = boot_end & (tgt_r == TGT_FIRST);
		stat_set[ST_REFRESH]   = tmr_exp;
		stat_set[ST_SYNC_LOST] = sync_lost;
		stat_set[ST_FAULT]     = fault_act & (state_r != TLP_FAULT);
		stat_clr = (apb_access && !i_pwrite && i_paddr == REG_STAT) ? prdata_r[STAT_W-1:0] : '0;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			stat_r <= '0;
		end else if (i_clk_en) begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
		end
	end

	assign o_irq = |(stat_r & mask_r);

	// assertion helpers: low pulse length and refresh count on the lead phase
	tlp_lvl_t     lead;
	logic         lead_low;
	logic [ONC_W:0] hl_len_r;
	logic [6:0]   hp_cnt_r;
	assign lead     = tied_r[0] ? lvl[1] : lvl[0];
	assign lead_low = is_low(lead);
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			hl_len_r <= '0;
			hp_cnt_r <= 7'h00;
		end else if (i_clk_en) begin
			hl_len_r <= lead_low ? hl_len_r + 1'b1 : '0;
			if (!boot) begin
				hp_cnt_r <= 7'h00;
			end else if (lead_low && hl_len_r == '0) begin
				hp_cnt_r <= hp_cnt_r + 7'h01;
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst || !i_clk_en);

	AST_FAULT_MID: assert property ((state_r == TLP_FAULT) |=>
		(o_phase_one_pwm_out == LVL_MID) && (o_phase_two_pwm_out == LVL_MID))
		else $error("pwm not mid during fault");
	AST_SYNC_LOW_FAULT: assert property ((state_r == TLP_FAULT) ##1 (state_r == TLP_FAULT) |-> !o_sync_out)
		else $error("sync out toggling during fault");
	AST_CMP_ENDS_HIGH: assert property ((run && is_high(lvl[0]) && i_cur_cmp[0] && !hi_set[0]) |=>
		is_low(lvl[0]))
		else $error("comparator did not end high pulse");
	AST_MIN_ON: assert property (($past(lead_low) && !lead_low && $past(boot)) |->
		(hl_len_r == MIN_ON_LEN))
		else $error("refresh low pulse width wrong");
	AST_BOOT_COUNT: assert property (boot_end |-> (hp_cnt_r == {1'b0, tgt_r}))
		else $error("wrong number of refresh pulses");
	AST_TIMER_REFRESH: assert property ((tmr_exp && ctrl_en_r && ctrl_tri_r && !fault_act) |->
		##[1:1000] (boot && tgt_r == TGT_EXTRA) or (!ctrl_tri_r || !ctrl_en_r || fault_act) ##0 1'b1)
		else $error("no extra refresh after timer expiry");
	AST_HIGH_CLEARS: assert property ((|hi_set) |=> (tmr_r == '0) && armed_r)
		else $error("high command did not clear tristate timer");
	AST_PH2_ODD_TICK: assert property ((!is_high(lvl[1]) ##1 is_high(lvl[1])) |-> $past(toggle_r))
		else $error("phase two started on wrong tick");
	AST_TIED_MID: assert property ((strap_done_r && tied_r[0]) |-> (lvl[0] == LVL_MID))
		else $error("tied phase is switching");
	AST_SYNC_OPEN: assert property ((so_mode_r == SO_OPEN && state_r != TLP_FAULT &&
		$past(state_r) != TLP_FAULT) |=> (o_sync_out == $past(is_high(lvl[1]))))
		else $error("open sync out not following phase two");

	COV_BOOT_DONE: cover property (boot_end && tgt_r == TGT_FIRST);
	COV_EXTRA_REFRESH: cover property (boot_end && tgt_r == TGT_EXTRA);
	COV_LOCKED_RUN: cover property (locked && run && (|hi_set));
	COV_FAULT: cover property (state_r == TLP_FAULT ##1 state_r == TLP_IDLE);
endmodule

`default_nettype wire

// *** verification/tlp_drv_model.sv ***
// behavioural half-bridge driver with a current-sense ramp for the pwm outputs
`default_nettype none

module tlp_drv_model #(
	parameter int unsigned RAMP = 10
) (
	// clock
	input  wire logic              i_sys_clk,
	// tri-level commands
	input  wire tlp_pkg::tlp_lvl_t i_lvl_one,
	input  wire tlp_pkg::tlp_lvl_t i_lvl_two,
	// comparator trip per phase
	output logic [1:0]             o_cur_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	import tlp_pkg::*;

	logic        hs_on [2];
	logic        ls_on [2];
	int unsigned ramp_cnt [2] = '{0, 0};

	// high drives the top fet, low the bottom fet, mid neither
	always_comb begin
		hs_on[0] = (i_lvl_one === LVL_HIGH);
		hs_on[1] = (i_lvl_two === LVL_HIGH);
		ls_on[0] = (i_lvl_one === LVL_LOW);
		ls_on[1] = (i_lvl_two === LVL_LOW);
	end

	// current climbs only while the top fet conducts, so a missed trip shows as a long pulse
	always @(posedge i_sys_clk) begin
		for (int i = 0; i < 2; i++) begin
			ramp_cnt[i] <= hs_on[i] ? ramp_cnt[i] + 1 : 0;
		end
	end

	// trip stands until the top fet is released
	assign o_cur_cmp[0] = hs_on[0] && (ramp_cnt[0] >= RAMP);
	assign o_cur_cmp[1] = hs_on[1] && (ramp_cnt[1] >= RAMP);
endmodule

`default_nettype wire

// *** verification/tri_level_dual_phase_pwm_sequencer_tb.sv ***
// self-checking bench for the tri-level dual-phase pwm sequencer
`default_nettype none

module tri_level_dual_phase_pwm_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tlp_pkg::*;

	localparam int unsigned MON = 4;
	localparam int unsigned TRI = 200;
	localparam int unsigned PER = 100;
	localparam int unsigned RAMP = 10;
	localparam int unsigned SYN = 80;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        fss = 1'b0;
	logic [1:0]  tied = 2'h0;
	logic [1:0]  sos = SO_OPEN;
	logic        sin = 1'b0;
	logic        sync_run = 1'b0;
	logic        so_p = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sync_out;
	logic        irq;
	logic [1:0]  cmp;
	tlp_lvl_t    p1;
	tlp_lvl_t    p2;
	tlp_lvl_t    lv;
	tlp_lvl_t    pv [2] = '{LVL_MID, LVL_MID};
	int          lo [2] = '{0, 0};
	int          lw [2] = '{0, 0};
	int          hw [2] = '{0, 0};
	int          wd [2] = '{0, 0};
	int          r1 = 0;
	int          off = 0;
	int          cyc = 0;
	int          miscompares = 0;
	int          check_count = 0;
	int          scnt = 0;
	int          so_t = 0;
	int          so_per = 0;

	tlp_seq #(.MIN_ON(MON), .TRI_CYCLES(TRI)) tlp_seq_inst (
		.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_phase_tied_vcc(tied), .i_sync_out_strap(sos), .i_freq_set_short(fss),
		.i_sync_in(sin), .i_cur_cmp(cmp),
		.o_phase_one_pwm_out(p1), .o_phase_two_pwm_out(p2), .o_sync_out(sync_out), .o_irq(irq)
	);

	tlp_drv_model #(.RAMP(RAMP)) tlp_drv_model_inst (
		.i_sys_clk(clk), .i_lvl_one(p1), .i_lvl_two(p2), .o_cur_cmp(cmp)
	);

	// clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	// level monitor on the falling edge, clear of the launch edge
	always @(negedge clk) begin
		cyc++;
		for (int i = 0; i < 2; i++) begin
			lv = i ? p2 : p1;
			if (lv !== pv[i]) begin
				if (pv[i] === LVL_LOW) lw[i] = wd[i];
				if (pv[i] === LVL_HIGH) hw[i] = wd[i];
				if (lv === LVL_LOW && pv[i] === LVL_MID) lo[i]++;
				if (lv === LVL_HIGH && i == 1) off = cyc - r1;
				if (lv === LVL_HIGH && i == 0) r1 = cyc;
				wd[i] = 1;
			end else begin
				wd[i]++;
			end
			pv[i] = lv;
		end
		// sync out period, rise to rise
		if (sync_out === 1'b1 && so_p !== 1'b1) begin
			so_per = cyc - so_t;
			so_t = cyc;
		end
		so_p = sync_out;
	end

	// external sync source at 2.5 MHz, faster than the internal rate so it keeps the lock
	always @(posedge clk) begin
		scnt <= (scnt == SYN - 1) ? 0 : scnt + 1;
		sin <= sync_run && (scnt < SYN / 2);
	end

	task automatic end_sim();
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_lvl(input tlp_lvl_t got, input tlp_lvl_t exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// apb transfer: request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h00000000, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, experr});
	endtask

	// poll the state register, bounded
	task automatic wait_state(input logic [4:0] s);
		logic [31:0] q;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, REG_STATE, 32'h00000000, q, e);
			n++;
		end while (q[4:0] !== s && n < 5000);
		chk({27'h0, q[4:0]}, {27'h0, s});
	endtask

	task automatic t_regs();
		rd_chk(REG_CTRL, 32'h00000000, 1'b0);
		rd_chk(REG_OSC, 32'h000000C8, 1'b0);
		rd_chk(REG_MASK, 32'h00000000, 1'b0);
		rd_chk(REG_STATE, 32'h00000001, 1'b0);
		rd_chk(8'h40, 32'h00000000, 1'b1);
		wr(REG_MASK, 32'h0000000F);
		rd_chk(REG_MASK, 32'h0000000F, 1'b0);
		wr(REG_MASK, 32'h00000000);
	endtask

	task automatic t_boot();
		wr(REG_OSC, PER);
		wr(REG_CTRL, 32'h00000001);
		wait_state(5'h04);
		chk(lo[0], 32);
		chk(lo[1], 32);
		chk(lw[0], MON);
		chk(lw[1], MON);
		rd_chk(REG_STAT, 32'h00000001, 1'b0);
		rd_chk(REG_STAT, 32'h00000000, 1'b0);
	endtask

	task automatic t_run();
		repeat (6 * PER) @(posedge clk);
		chk({31'h0, (hw[0] >= RAMP && hw[0] <= RAMP + 3)}, 32'h00000001);
		chk({31'h0, (hw[1] >= RAMP && hw[1] <= RAMP + 3)}, 32'h00000001);
		chk(off, PER);
	endtask

	// tristate long enough for the timer, then prove it is one-shot
	task automatic t_tri();
		int s0;
		int s1;
		s0 = lo[0];
		s1 = lo[1];
		wr(REG_CTRL, 32'h00000003);
		wait_state(5'h08);
		repeat (16 * PER) @(posedge clk);
		chk(lo[0] - s0, 4);
		chk(lo[1] - s1, 4);
		rd_chk(REG_STAT, 32'h00000002, 1'b0);
		@(negedge clk);
		chk_lvl(p1, LVL_MID);
		repeat (15 * PER) @(posedge clk);
		chk(lo[0] - s0, 4);
		wr(REG_CTRL, 32'h00000001);
		wait_state(5'h04);
	endtask

	task automatic t_fault();
		int s0;
		wr(REG_MASK, 32'h00000008);
		fss <= 1'b1;
		repeat (6) @(posedge clk);
		s0 = lo[0] + lo[1];
		@(negedge clk);
		chk_lvl(p1, LVL_MID);
		chk_lvl(p2, LVL_MID);
		chk({31'h0, irq}, 32'h00000001);
		repeat (4 * PER) begin
			@(negedge clk);
			chk({31'h0, sync_out}, 32'h00000000);
		end
		chk(lo[0] + lo[1], s0);
		rd_chk(REG_STAT, 32'h00000008, 1'b0);
		@(negedge clk);
		chk({31'h0, irq}, 32'h00000000);
		@(posedge clk);
		fss <= 1'b0;
	endtask

	// second reset: phase one strapped high, switching-rate sync out, external sync then loss
	task automatic t_sync();
		int s0;
		int s1;
		s0 = lo[0];
		s1 = lo[1];
		nrst <= 1'b0;
		tied <= 2'h1;
		sos <= SO_SW;
		sync_run <= 1'b1;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wr(REG_OSC, PER);
		wr(REG_CTRL, 32'h00000001);
		wait_state(5'h04);
		rd_chk(REG_STATE, 32'h00000264, 1'b0);
		chk(lo[0], s0);
		chk(lo[1] - s1, 32);
		chk(lw[1], MON);
		repeat (4 * SYN) @(posedge clk);
		chk(so_per, 2 * SYN);
		sync_run <= 1'b0;
		repeat (6 * PER) @(posedge clk);
		chk(so_per, 2 * PER);
		rd_chk(REG_STAT, 32'h00000005, 1'b0);
	endtask

	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_boot();
		t_run();
		t_tri();
		t_fault();
		t_sync();
		end_sim();
	end
endmodule

`default_nettype wire
